// ===== rtl/csf_flags.v
// CPU condition register with flag generation for the core's ALU operations
// Overview of operation
// - Eight flag bits; C Z S V jump-testable
// - Bit 0 reports selected register bank
// - Half-zero op clears bank, half-one sets
// - Register writable by non-flag instructions
// - AND updates zero, sign and overflow
// - Flag op targeting register collides; unpredictable
// - Carry set on carry or borrow MSB
// - Rotate or shift leaves last bit in carry
// - Carry force one, zero, or invert
// - Zero set when arithmetic/logic result zero
// - Zero set for bit test, rotate zero
// - Sign copies result MSB
// - Overflow on signed eight-bit range exceed
// - Logic operations clear overflow
// - Decimal bit records add or subtract
// - Half-carry from bit 3 or borrow bit 4
// - BCD fix-up uses half-carry and decimal bit
// - Fast status set in cycle, exit clears
// - Fast status blocks interrupts, selects fast return
// - Register lives at file address D5 hex
`timescale 1ns/1ps
`include "csf_map.vh"
module csf_flags #(
    parameter DW = 8
) (
    input wire sys_clk,
    input wire rst,
    input wire op_valid,
    input wire [4:0] op_code,
    input wire [DW-1:0] op_a,
    input wire [DW-1:0] op_b,
    input wire fast_irq_start,
    input wire reg_wr_en,
    input wire [7:0] reg_wr_addr,
    input wire [7:0] reg_wr_data,
    input wire reg_rd_en,
    input wire [7:0] reg_rd_addr,
    output reg [7:0] flags_r,
    output reg [3:0] jump_flags_r,
    output reg irq_block_r,
    output reg fast_return_r,
    output reg [DW-1:0] result_r,
    output reg result_valid_r,
    output reg [7:0] reg_rd_data_r,
    output reg reg_rd_hit_r,
    output reg collide_r
);

    // Ops ADD through CFI that write flags; decoded only for the collision check
    function flag_op;
        input [4:0] op;
        begin
            case (op)
                `CSF_OP_NOP, `CSF_OP_SH0, `CSF_OP_SH1: flag_op = 1'b0;
                `CSF_OP_EXIT: flag_op = 1'b0;
                default: flag_op = (op <= `CSF_OP_CFI);
            endcase
        end
    endfunction

    function [7:0] hit_addr;
        input [7:0] addr;
        begin
            hit_addr = {7'h00, addr == `CSF_FLAGS_ADDR};
        end
    endfunction

    reg [7:0] flags_nxt;
    reg [DW-1:0] res;
    reg res_wr;
    reg cout;
    reg hc;
    reg [DW:0] sum;
    reg [4:0] nib;
    reg [DW-1:0] corr;
    reg cin;
    wire c_now = flags_r[`CSF_BIT_C];
    wire reg_hit = reg_wr_en && hit_addr(reg_wr_addr) != 8'h00;
    wire op_flags = op_valid && flag_op(op_code);

    always @* begin
        flags_nxt = flags_r;
        res = op_a;
        res_wr = 1'b0;
        sum = {(DW+1){1'b0}};
        nib = 5'h00;
        corr = {DW{1'b0}};
        cout = 1'b0;
        hc = 1'b0;
        cin = 1'b0;
        if (op_valid) begin
            case (op_code)
                `CSF_OP_ADD, `CSF_OP_ADC, `CSF_OP_INC: begin
                    cin = (op_code == `CSF_OP_ADC) ? c_now : 1'b0;
                    if (op_code == `CSF_OP_INC) begin
                        sum = {1'b0, op_a} + {{DW{1'b0}}, 1'b1};
                    end else begin
                        sum = {1'b0, op_a} + {1'b0, op_b} + {{DW{1'b0}}, cin};
                    end
                    res = sum[DW-1:0];
                    res_wr = 1'b1;
                    flags_nxt[`CSF_BIT_V] = (op_a[DW-1] == (op_code == `CSF_OP_INC ? 1'b0 :
                        op_b[DW-1])) && (res[DW-1] != op_a[DW-1]);
                    if (op_code != `CSF_OP_INC) begin
                        nib = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
                        flags_nxt[`CSF_BIT_C] = sum[DW];
                        flags_nxt[`CSF_BIT_H] = nib[4];
                        flags_nxt[`CSF_BIT_D] = 1'b0;
                    end
                end
                `CSF_OP_SUB, `CSF_OP_SBC, `CSF_OP_CP, `CSF_OP_DEC: begin
                    cin = (op_code == `CSF_OP_SBC) ? c_now : 1'b0;
                    if (op_code == `CSF_OP_DEC) begin
                        sum = {1'b0, op_a} - {{DW{1'b0}}, 1'b1};
                    end else begin
                        sum = {1'b0, op_a} - {1'b0, op_b} - {{DW{1'b0}}, cin};
                    end
                    res = sum[DW-1:0];
                    res_wr = (op_code != `CSF_OP_CP);
                    flags_nxt[`CSF_BIT_V] = (op_a[DW-1] != (op_code == `CSF_OP_DEC ? 1'b0 :
                        op_b[DW-1])) && (res[DW-1] != op_a[DW-1]);
                    if (op_code != `CSF_OP_DEC) begin
                        flags_nxt[`CSF_BIT_C] = sum[DW];
                    end
                    if (op_code == `CSF_OP_SUB || op_code == `CSF_OP_SBC) begin
                        nib = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, cin};
                        flags_nxt[`CSF_BIT_H] = nib[4];
                        flags_nxt[`CSF_BIT_D] = 1'b1;
                    end
                end
                `CSF_OP_AND, `CSF_OP_OR, `CSF_OP_XOR, `CSF_OP_COM, `CSF_OP_TM: begin
                    case (op_code)
                        `CSF_OP_AND: res = op_a & op_b;
                        `CSF_OP_OR: res = op_a | op_b;
                        `CSF_OP_XOR: res = op_a ^ op_b;
                        `CSF_OP_COM: res = ~op_a;
                        default: res = op_a & op_b;
                    endcase
                    res_wr = (op_code != `CSF_OP_TM);
                    flags_nxt[`CSF_BIT_V] = 1'b0;
                end
                `CSF_OP_RL, `CSF_OP_RLC: begin
                    cin = (op_code == `CSF_OP_RLC) ? c_now : op_a[DW-1];
                    res = {op_a[DW-2:0], cin};
                    res_wr = 1'b1;
                    flags_nxt[`CSF_BIT_C] = op_a[DW-1];
                    flags_nxt[`CSF_BIT_V] = op_a[DW-1] ^ res[DW-1];
                end
                `CSF_OP_RR, `CSF_OP_RRC, `CSF_OP_SRA: begin
                    case (op_code)
                        `CSF_OP_RR: cin = op_a[0];
                        `CSF_OP_RRC: cin = c_now;
                        default: cin = op_a[DW-1];
                    endcase
                    res = {cin, op_a[DW-1:1]};
                    res_wr = 1'b1;
                    flags_nxt[`CSF_BIT_C] = op_a[0];
                    flags_nxt[`CSF_BIT_V] = op_a[DW-1] ^ res[DW-1];
                end
                `CSF_OP_BCD: begin
                    // Correction steered by the last op kind, half-carry and carry
                    cout = c_now;
                    if (flags_r[`CSF_BIT_H] ||
                        (!flags_r[`CSF_BIT_D] && op_a[3:0] > 4'h9)) begin
                        corr[3:0] = 4'h6;
                    end
                    if (c_now || (!flags_r[`CSF_BIT_D] && op_a > 8'h99)) begin
                        corr[DW-1:4] = 4'h6;
                        cout = 1'b1;
                    end
                    res = flags_r[`CSF_BIT_D] ? op_a - corr : op_a + corr;
                    res_wr = 1'b1;
                    flags_nxt[`CSF_BIT_C] = cout;
                end
                `CSF_OP_CF1: flags_nxt[`CSF_BIT_C] = 1'b1;
                `CSF_OP_CF0: flags_nxt[`CSF_BIT_C] = 1'b0;
                `CSF_OP_CFI: flags_nxt[`CSF_BIT_C] = ~c_now;
                `CSF_OP_SH0: flags_nxt[`CSF_BIT_BA] = 1'b0;
                `CSF_OP_SH1: flags_nxt[`CSF_BIT_BA] = 1'b1;
                `CSF_OP_EXIT: flags_nxt[`CSF_BIT_FIS] = 1'b0;
                default: flags_nxt = flags_r;
            endcase
            if (op_code <= `CSF_OP_BCD && op_code != `CSF_OP_NOP) begin
                flags_nxt[`CSF_BIT_Z] = (res == {DW{1'b0}});
                flags_nxt[`CSF_BIT_S] = res[DW-1];
            end
        end
        if (fast_irq_start) begin
            flags_nxt[`CSF_BIT_FIS] = 1'b1;
        end
        // A software load wins over a same-cycle flag update; the result is
        // only guaranteed for loads that do not coincide with flag ops
        if (reg_hit) begin
            flags_nxt = reg_wr_data;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            flags_r <= `CSF_FLAGS_RST;
            jump_flags_r <= 4'h0;
            irq_block_r <= 1'b0;
            fast_return_r <= 1'b0;
            result_r <= {DW{1'b0}};
            result_valid_r <= 1'b0;
            reg_rd_data_r <= 8'h00;
            reg_rd_hit_r <= 1'b0;
            collide_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            jump_flags_r <= flags_nxt[`CSF_BIT_C:`CSF_BIT_V];
            irq_block_r <= flags_nxt[`CSF_BIT_FIS];
            fast_return_r <= op_valid && op_code == `CSF_OP_EXIT &&
                flags_r[`CSF_BIT_FIS];
            result_r <= res;
            result_valid_r <= res_wr;
            reg_rd_hit_r <= reg_rd_en && hit_addr(reg_rd_addr) != 8'h00;
            reg_rd_data_r <= (reg_rd_en && hit_addr(reg_rd_addr) != 8'h00) ?
                flags_r : 8'h00;
            collide_r <= reg_hit && op_flags;
        end
    end

endmodule

// ===== rtl/csf_map.vh
// Constants for the CPU condition register block
`ifndef CSF_MAP_VH
`define CSF_MAP_VH
`define CSF_FLAGS_ADDR 8'hD5
`define CSF_FLAGS_RST 8'h00
`define CSF_BIT_C 7
`define CSF_BIT_Z 6
`define CSF_BIT_S 5
`define CSF_BIT_V 4
`define CSF_BIT_D 3
`define CSF_BIT_H 2
`define CSF_BIT_FIS 1
`define CSF_BIT_BA 0
`define CSF_OP_NOP 5'h00
`define CSF_OP_ADD 5'h01
`define CSF_OP_ADC 5'h02
`define CSF_OP_SUB 5'h03
`define CSF_OP_SBC 5'h04
`define CSF_OP_CP 5'h05
`define CSF_OP_AND 5'h06
`define CSF_OP_OR 5'h07
`define CSF_OP_XOR 5'h08
`define CSF_OP_COM 5'h09
`define CSF_OP_INC 5'h0A
`define CSF_OP_DEC 5'h0B
`define CSF_OP_RL 5'h0C
`define CSF_OP_RLC 5'h0D
`define CSF_OP_RR 5'h0E
`define CSF_OP_RRC 5'h0F
`define CSF_OP_SRA 5'h10
`define CSF_OP_TM 5'h11
`define CSF_OP_BCD 5'h12
`define CSF_OP_CF1 5'h13
`define CSF_OP_CF0 5'h14
`define CSF_OP_CFI 5'h15
`define CSF_OP_SH0 5'h16
`define CSF_OP_SH1 5'h17
`define CSF_OP_EXIT 5'h18
`endif

// ===== dv/csf_flags_assertions.sv
// Port-level checks on the condition register block
`timescale 1ns/1ps
`include "csf_map.vh"
module csf_flags_assertions #(
    parameter DW = 8
) (
    input logic sys_clk,
    input logic rst,
    input logic op_valid,
    input logic [4:0] op_code,
    input logic fast_irq_start,
    input logic reg_wr_en,
    input logic [7:0] reg_wr_addr,
    input logic [7:0] reg_wr_data,
    input logic reg_rd_en,
    input logic [7:0] reg_rd_addr,
    input logic [7:0] flags_r,
    input logic [3:0] jump_flags_r,
    input logic irq_block_r,
    input logic fast_return_r,
    input logic [DW-1:0] result_r,
    input logic [7:0] reg_rd_data_r,
    input logic reg_rd_hit_r,
    input logic collide_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Direct writes win over every flag source, so the op checks exclude them
    wire wr_hit = reg_wr_en && reg_wr_addr == `CSF_FLAGS_ADDR;
    wire op_is = op_valid && !wr_hit;
    a_jump_mirror: assert property (jump_flags_r == flags_r[7:4])
        else $error("jump flags differ");
    a_block_mirror: assert property (irq_block_r == flags_r[1])
        else $error("block differs from fast bit");
    a_bank_clear: assert property (op_is && op_code == `CSF_OP_SH0 |=> !flags_r[0])
        else $error("bank bit not cleared");
    a_direct_write: assert property (wr_hit |=> flags_r == $past(reg_wr_data))
        else $error("direct write lost");
    a_collide_seen: assert property (wr_hit && op_valid && op_code >= `CSF_OP_ADD
        && op_code <= `CSF_OP_CFI |=> collide_r) else $error("no collide pulse");
    a_add_zero_sign: assert property (op_is && op_code == `CSF_OP_ADD |=>
        flags_r[6] == (result_r == '0) && flags_r[5] == result_r[DW-1])
        else $error("zero or sign wrong");
    a_logic_ovf: assert property (op_is && (op_code == `CSF_OP_AND || op_code == `CSF_OP_OR
        || op_code == `CSF_OP_XOR) |=> !flags_r[4]) else $error("overflow kept");
    a_carry_invert: assert property (op_is && !fast_irq_start && op_code == `CSF_OP_CFI
        |=> flags_r == ($past(flags_r) ^ 8'h80)) else $error("carry invert wrong");
    a_fast_exit: assert property (op_is && !fast_irq_start && op_code == `CSF_OP_EXIT
        && flags_r[1] |=> fast_return_r && !flags_r[1]) else $error("bad exit");
    a_read_back: assert property (reg_rd_en && reg_rd_addr == `CSF_FLAGS_ADDR |=>
        reg_rd_hit_r && reg_rd_data_r == $past(flags_r)) else $error("bad read");
endmodule
bind csf_flags csf_flags_assertions #(.DW(DW)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .fast_irq_start(fast_irq_start), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr),
    .flags_r(flags_r), .jump_flags_r(jump_flags_r), .irq_block_r(irq_block_r),
    .fast_return_r(fast_return_r), .result_r(result_r), .reg_rd_data_r(reg_rd_data_r),
    .reg_rd_hit_r(reg_rd_hit_r), .collide_r(collide_r));

// ===== dv/testbench.sv
// Self-checking bench for the condition register block
`timescale 1ns/1ps
`include "csf_map.vh"
module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic op_valid = 1'b0, fast_irq_start = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
    logic [4:0] op_code = 5'h00;
    logic [7:0] op_a = 8'h00, op_b = 8'h00, reg_wr_addr = 8'h00, reg_wr_data = 8'h00;
    logic [7:0] reg_rd_addr = 8'h00, flags_r, result_r, reg_rd_data_r;
    logic [3:0] jump_flags_r;
    logic irq_block_r, fast_return_r, result_valid_r, reg_rd_hit_r, collide_r;
    integer errors = 0, checks = 0, cycles = 0;
    csf_flags #(.DW(8)) dut (.sys_clk(sys_clk), .rst(rst), .op_valid(op_valid),
        .op_code(op_code), .op_a(op_a), .op_b(op_b), .fast_irq_start(fast_irq_start),
        .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
        .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr), .flags_r(flags_r),
        .jump_flags_r(jump_flags_r), .irq_block_r(irq_block_r), .fast_return_r(fast_return_r),
        .result_r(result_r), .result_valid_r(result_valid_r), .reg_rd_data_r(reg_rd_data_r),
        .reg_rd_hit_r(reg_rd_hit_r), .collide_r(collide_r));
    always #2 sys_clk = ~sys_clk;
    task cmp8(input [7:0] got, input [7:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Ops are spaced by an idle cycle so no strobe is lowered and raised in one step
    task opf(input [4:0] c, input [7:0] a, input [7:0] b, input [7:0] res, input [7:0] flg);
        @(posedge sys_clk);
        #1;
        op_code = c;
        op_a = a;
        op_b = b;
        op_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        op_valid = 1'b0;
        if (c <= `CSF_OP_BCD)
            cmp8(result_r, res);
        cmp8(flags_r, flg);
    endtask
    task rd(input [7:0] ad, input [7:0] exp, input [7:0] hit);
        @(posedge sys_clk);
        #1;
        reg_rd_addr = ad;
        reg_rd_en = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_rd_en = 1'b0;
        cmp8(reg_rd_data_r, exp);
        cmp8({7'h00, reg_rd_hit_r}, hit);
    endtask
    task wr(input [7:0] ad, input [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_wr_addr = ad;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr_en = 1'b0;
    endtask
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            errors = errors + 1;
            end_of_test;
        end
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        cmp8(flags_r, `CSF_FLAGS_RST);
        opf(`CSF_OP_ADD, 8'h7F, 8'h01, 8'h80, 8'h34);
        cmp8({7'h00, result_valid_r}, 8'h01);
        opf(`CSF_OP_AND, 8'hF0, 8'h80, 8'h80, 8'h24);
        opf(`CSF_OP_ADD, 8'hFF, 8'h01, 8'h00, 8'hC4);
        opf(`CSF_OP_SUB, 8'h00, 8'h01, 8'hFF, 8'hAC);
        opf(`CSF_OP_RL, 8'h80, 8'h00, 8'h01, 8'h9C);
        opf(`CSF_OP_SRA, 8'h01, 8'h00, 8'h00, 8'hCC);
        opf(`CSF_OP_CF0, 8'h00, 8'h00, 8'h00, 8'h4C);
        opf(`CSF_OP_CF1, 8'h00, 8'h00, 8'h00, 8'hCC);
        opf(`CSF_OP_CFI, 8'h00, 8'h00, 8'h00, 8'h4C);
        opf(`CSF_OP_SH1, 8'h00, 8'h00, 8'h00, 8'h4D);
        opf(`CSF_OP_SH0, 8'h00, 8'h00, 8'h00, 8'h4C);
        wr(`CSF_FLAGS_ADDR, 8'hA5);
        cmp8({4'h0, jump_flags_r}, 8'h0A);
        rd(`CSF_FLAGS_ADDR, 8'hA5, 8'h01);
        wr(8'hD4, 8'h00);
        rd(8'hD4, 8'h00, 8'h00);
        reg_wr_addr = `CSF_FLAGS_ADDR;
        reg_wr_data = 8'h00;
        reg_wr_en = 1'b1;
        opf(`CSF_OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h00);
        cmp8({7'h00, collide_r}, 8'h01);
        reg_wr_en = 1'b0;
        opf(`CSF_OP_ADD, 8'h09, 8'h08, 8'h11, 8'h04);
        opf(`CSF_OP_BCD, 8'h11, 8'h00, 8'h17, 8'h04);
        fast_irq_start = 1'b1;
        @(posedge sys_clk);
        #1;
        fast_irq_start = 1'b0;
        cmp8({flags_r[7:2], irq_block_r, flags_r[0]}, 8'h06);
        opf(`CSF_OP_EXIT, 8'h00, 8'h00, 8'h00, 8'h04);
        cmp8({6'h00, fast_return_r, irq_block_r}, 8'h02);
        opf(`CSF_OP_INC, 8'h7F, 8'h00, 8'h80, 8'h34);
        opf(`CSF_OP_DEC, 8'h80, 8'h00, 8'h7F, 8'h14);
        opf(`CSF_OP_CF1, 8'h00, 8'h00, 8'h00, 8'h94);
        opf(`CSF_OP_ADC, 8'h01, 8'h01, 8'h03, 8'h00);
        opf(`CSF_OP_CF1, 8'h00, 8'h00, 8'h00, 8'h80);
        opf(`CSF_OP_SBC, 8'h05, 8'h02, 8'h02, 8'h08);
        opf(`CSF_OP_CP, 8'h05, 8'h05, 8'h00, 8'h48);
        cmp8({7'h00, result_valid_r}, 8'h00);
        opf(`CSF_OP_OR, 8'h0F, 8'hF0, 8'hFF, 8'h28);
        opf(`CSF_OP_XOR, 8'hFF, 8'hFF, 8'h00, 8'h48);
        opf(`CSF_OP_COM, 8'h00, 8'h00, 8'hFF, 8'h28);
        opf(`CSF_OP_TM, 8'h0F, 8'hF0, 8'h00, 8'h48);
        cmp8({7'h00, result_valid_r}, 8'h00);
        opf(`CSF_OP_RLC, 8'h81, 8'h00, 8'h02, 8'h98);
        opf(`CSF_OP_RRC, 8'h01, 8'h00, 8'h80, 8'hB8);
        opf(`CSF_OP_RR, 8'h02, 8'h00, 8'h01, 8'h08);
        opf(5'h1F, 8'h00, 8'h00, 8'h00, 8'h08);
        end_of_test;
    end
endmodule
